// File: logic/mfl_nvm_ctrl.sv
// staging registers, store/reload sequencer and fault-log gate
`timescale 1ns/100ps
module mfl_nvm_ctrl #(
	parameter int unsigned FULL_CYCLES = mfl_pkg::FULL_STORE_CYCLES,
	parameter int unsigned WORD_CYCLES = mfl_pkg::WORD_STORE_CYCLES
) (
	input wire logic clk, // system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic [7:0] reg_addr, // register address
	input wire logic reg_wr, // register write strobe
	input wire logic reg_rd, // register read strobe
	input wire logic [7:0] reg_wdata, // write data
	output logic [7:0] reg_rdata, // read data
	output logic reg_rvalid, // read data valid pulse
	output logic [7:0] cfg_rd_addr, // configuration read address
	input wire logic [7:0] cfg_rd_data, // configuration byte at cfg_rd_addr
	output logic cfg_wr, // configuration write strobe
	output logic [7:0] cfg_wr_addr, // configuration write address
	output logic [7:0] cfg_wr_data, // configuration write data
	input wire logic fault_valid, // fault crossing pulse
	input wire logic [2:0] fault_chan, // 0 local, 1..4 remote
	input wire logic [15:0] fault_temp, // fault temperature
	input wire logic [7:0] fault_status, // status bits at the fault
	output logic nvm_busy // sequencer working
);

	// -------------------------------------------------------------
	// state
	// -------------------------------------------------------------
	logic [7:0] log_en_q, log_en_d;
	logic [7:0] cmd_q, cmd_d;
	logic [7:0] taddr_q, taddr_d;
	logic [7:0] din_hi_q, din_hi_d;
	logic [7:0] din_lo_q, din_lo_d;
	mfl_pkg::mfl_state_t st_q, st_d;
	mfl_pkg::mfl_op_t op_q, op_d;
	logic [7:0] ptr_q, ptr_d;
	logic [7:0] last_q, last_d;
	logic phase_q, phase_d;
	logic [31:0] wait_q, wait_d;
	logic pend_q, pend_d;
	logic [7:0] pend_base_q, pend_base_d;
	logic [15:0] pend_temp_q, pend_temp_d;
	logic [7:0] pend_stat_q, pend_stat_d;
	logic [7:0] cfg_rd_addr_d, cfg_wr_addr_d, cfg_wr_data_d;
	logic cfg_wr_d, busy_d;
	logic mem_we;
	logic [7:0] mem_wdata;
	logic [7:0] mem_a_rdata, mem_b_rdata;
	localparam int NVM_CHAN_W = mfl_pkg::NUM_CHAN;
	logic [NVM_CHAN_W-1:0] chan_gate;
	logic accept;
	logic [7:0] mem_wsrc;

	// -------------------------------------------------------------
	// per-channel logging gate
	// -------------------------------------------------------------
	for (genvar c = 0; c < NVM_CHAN_W; c++)
	begin : g_gate
		assign chan_gate[c] = log_en_q[mfl_pkg::LOG_MASTER_BIT] & log_en_q[c];
	end

	always_comb
	begin
		accept = 1'b0;
		if (fault_valid && fault_chan < 3'(NVM_CHAN_W))
		begin
			accept = chan_gate[fault_chan];
		end
	end

	// source byte for a nonvolatile write
	always_comb
	begin
		mem_wsrc = cfg_rd_data;
		if (op_q == mfl_pkg::OP_MANUAL)
		begin
			mem_wsrc = ptr_q[0] ? din_lo_q : din_hi_q;
		end
		else if (op_q == mfl_pkg::OP_LOG)
		begin
			if (ptr_q == mfl_pkg::NVM_LOG_STATUS)
			begin
				mem_wsrc = pend_stat_q;
			end
			else
			begin
				mem_wsrc = ptr_q[0] ? pend_temp_q[7:0] : pend_temp_q[15:8];
			end
		end
	end

	// -------------------------------------------------------------
	// registers and sequencer
	// -------------------------------------------------------------
	always_comb
	begin
		log_en_d = log_en_q;
		cmd_d = cmd_q;
		taddr_d = taddr_q;
		din_hi_d = din_hi_q;
		din_lo_d = din_lo_q;
		st_d = st_q;
		op_d = op_q;
		ptr_d = ptr_q;
		last_d = last_q;
		phase_d = phase_q;
		wait_d = wait_q;
		pend_d = pend_q;
		pend_base_d = pend_base_q;
		pend_temp_d = pend_temp_q;
		pend_stat_d = pend_stat_q;
		cfg_rd_addr_d = cfg_rd_addr;
		cfg_wr_d = 1'b0;
		cfg_wr_addr_d = cfg_wr_addr;
		cfg_wr_data_d = cfg_wr_data;
		mem_we = 1'b0;
		mem_wdata = mem_wsrc;
		case (st_q)
			mfl_pkg::ST_IDLE:
			begin
				phase_d = 1'b0;
				wait_d = 32'(WORD_CYCLES);
				if (cmd_q[mfl_pkg::CMD_FULL_BIT])
				begin
					op_d = mfl_pkg::OP_FULL;
					ptr_d = mfl_pkg::NVM_CFG_FIRST;
					last_d = mfl_pkg::NVM_CFG_LAST;
					wait_d = 32'(FULL_CYCLES);
					st_d = mfl_pkg::ST_COPY;
				end
				else if (cmd_q[mfl_pkg::CMD_WORD_BIT])
				begin
					op_d = mfl_pkg::OP_WORD;
					ptr_d = taddr_q[0] ? taddr_q : taddr_q - 8'h01;
					last_d = taddr_q[0] ? taddr_q + 8'h01 : taddr_q;
					st_d = mfl_pkg::ST_COPY;
				end
				else if (cmd_q[mfl_pkg::CMD_RELOAD_BIT])
				begin
					op_d = mfl_pkg::OP_RELOAD;
					ptr_d = mfl_pkg::NVM_CFG_FIRST;
					last_d = mfl_pkg::NVM_CFG_LAST;
					wait_d = mfl_pkg::WAIT_ONE;
					st_d = mfl_pkg::ST_COPY;
				end
				else if (cmd_q[mfl_pkg::CMD_MANUAL_BIT])
				begin
					op_d = mfl_pkg::OP_MANUAL;
					ptr_d = {taddr_q[7:1], 1'b0};
					last_d = {taddr_q[7:1], 1'b1};
					st_d = mfl_pkg::ST_COPY;
				end
				else if (pend_q && log_en_q[mfl_pkg::LOG_MASTER_BIT])
				begin
					op_d = mfl_pkg::OP_LOG;
					ptr_d = pend_base_q;
					last_d = mfl_pkg::NVM_LOG_STATUS;
					st_d = mfl_pkg::ST_COPY;
				end
			end
			mfl_pkg::ST_COPY:
			begin
				if (!phase_q)
				begin
					cfg_rd_addr_d = ptr_q & mfl_pkg::SRAM_ADDR_MASK;
					phase_d = 1'b1;
				end
				else
				begin
					phase_d = 1'b0;
					if (op_q == mfl_pkg::OP_RELOAD)
					begin
						cfg_wr_d = 1'b1;
						cfg_wr_addr_d = ptr_q & mfl_pkg::SRAM_ADDR_MASK;
						cfg_wr_data_d = mem_b_rdata;
					end
					else
					begin
						mem_we = 1'b1;
					end
					if (ptr_q == last_q)
					begin
						st_d = mfl_pkg::ST_WAIT;
					end
					else if (op_q == mfl_pkg::OP_LOG && ptr_q[0])
					begin
						ptr_d = mfl_pkg::NVM_LOG_STATUS;
					end
					else
					begin
						ptr_d = ptr_q + 8'h01;
					end
				end
			end
			mfl_pkg::ST_WAIT:
			begin
				wait_d = wait_q - 32'h0000_0001;
				if (wait_q <= mfl_pkg::WAIT_ONE)
				begin
					st_d = mfl_pkg::ST_DONE;
				end
			end
			mfl_pkg::ST_DONE:
			begin
				st_d = mfl_pkg::ST_IDLE;
				case (op_q)
					mfl_pkg::OP_FULL: cmd_d[mfl_pkg::CMD_FULL_BIT] = 1'b0;
					mfl_pkg::OP_WORD: cmd_d[mfl_pkg::CMD_WORD_BIT] = 1'b0;
					mfl_pkg::OP_RELOAD: cmd_d[mfl_pkg::CMD_RELOAD_BIT] = 1'b0;
					mfl_pkg::OP_MANUAL: cmd_d[mfl_pkg::CMD_MANUAL_BIT] = 1'b0;
					default: pend_d = 1'b0;
				endcase
			end
			default:
			begin
				st_d = mfl_pkg::ST_IDLE;
			end
		endcase
		if (!log_en_q[mfl_pkg::LOG_MASTER_BIT] && st_q == mfl_pkg::ST_IDLE)
		begin
			pend_d = 1'b0;
		end
		if (accept && !pend_d)
		begin
			pend_d = 1'b1;
			pend_base_d = mfl_pkg::NVM_LOG_BASE + {4'h0, fault_chan, 1'b0};
			pend_temp_d = fault_temp;
			pend_stat_d = fault_status;
		end
		if (reg_wr)
		begin
			case (reg_addr)
				mfl_pkg::ADDR_LOG_EN: log_en_d = reg_wdata & mfl_pkg::LOG_EN_MASK;
				mfl_pkg::ADDR_CMD: cmd_d = reg_wdata & mfl_pkg::CMD_MASK;
				mfl_pkg::ADDR_TADDR: taddr_d = reg_wdata;
				mfl_pkg::ADDR_DIN_HI: din_hi_d = reg_wdata;
				mfl_pkg::ADDR_DIN_LO: din_lo_d = reg_wdata;
				default: ;
			endcase
		end
		busy_d = st_d != mfl_pkg::ST_IDLE;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			log_en_q <= mfl_pkg::LOG_EN_RST;
			cmd_q <= mfl_pkg::CMD_RST;
			taddr_q <= mfl_pkg::DATA_RST;
			din_hi_q <= mfl_pkg::DATA_RST;
			din_lo_q <= mfl_pkg::DATA_RST;
			st_q <= mfl_pkg::ST_IDLE;
			op_q <= mfl_pkg::OP_FULL;
			ptr_q <= 8'h00;
			last_q <= 8'h00;
			phase_q <= 1'b0;
			wait_q <= 32'h0000_0000;
			pend_q <= 1'b0;
			pend_base_q <= 8'h00;
			pend_temp_q <= 16'h0000;
			pend_stat_q <= 8'h00;
			cfg_rd_addr <= 8'h00;
			cfg_wr <= 1'b0;
			cfg_wr_addr <= 8'h00;
			cfg_wr_data <= 8'h00;
			nvm_busy <= 1'b0;
		end
		else
		begin
			log_en_q <= log_en_d;
			cmd_q <= cmd_d;
			taddr_q <= taddr_d;
			din_hi_q <= din_hi_d;
			din_lo_q <= din_lo_d;
			st_q <= st_d;
			op_q <= op_d;
			ptr_q <= ptr_d;
			last_q <= last_d;
			phase_q <= phase_d;
			wait_q <= wait_d;
			pend_q <= pend_d;
			pend_base_q <= pend_base_d;
			pend_temp_q <= pend_temp_d;
			pend_stat_q <= pend_stat_d;
			cfg_rd_addr <= cfg_rd_addr_d;
			cfg_wr <= cfg_wr_d;
			cfg_wr_addr <= cfg_wr_addr_d;
			cfg_wr_data <= cfg_wr_data_d;
			nvm_busy <= busy_d;
		end
	end

	// -------------------------------------------------------------
	// host read path, two cycles
	// -------------------------------------------------------------
	logic rd_q;
	logic [7:0] rd_addr_q;
	logic [7:0] rdata_d;

	always_comb
	begin
		rdata_d = 8'h00;
		if (rd_addr_q >= mfl_pkg::NVM_FIRST && rd_addr_q <= mfl_pkg::NVM_LAST)
		begin
			rdata_d = cmd_q[mfl_pkg::CMD_READ_BIT] ? mem_a_rdata : 8'h00;
		end
		else
		begin
			case (rd_addr_q)
				mfl_pkg::ADDR_LOG_EN: rdata_d = log_en_q;
				mfl_pkg::ADDR_CMD: rdata_d = cmd_q;
				mfl_pkg::ADDR_TADDR: rdata_d = taddr_q;
				mfl_pkg::ADDR_DIN_HI: rdata_d = din_hi_q;
				mfl_pkg::ADDR_DIN_LO: rdata_d = din_lo_q;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			rd_q <= 1'b0;
			rd_addr_q <= 8'h00;
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			rd_q <= reg_rd;
			rd_addr_q <= reg_addr;
			reg_rdata <= rd_q ? rdata_d : reg_rdata;
			reg_rvalid <= rd_q;
		end
	end

	// -------------------------------------------------------------
	// nonvolatile array
	// -------------------------------------------------------------
	mfl_nvm_mem #(
		.DEPTH(mfl_pkg::NVM_DEPTH),
		.AW(mfl_pkg::NVM_AW),
		.DW(mfl_pkg::NVM_DW)
	) u_mem (
		.clk(clk),
		.rstn(rstn),
		.wr_en(mem_we),
		.wr_addr(ptr_q[5:0]),
		.wr_data(mem_wdata),
		.a_addr(reg_addr[5:0]),
		.a_rdata(mem_a_rdata),
		.b_addr(ptr_q[5:0]),
		.b_rdata(mem_b_rdata)
	);

endmodule : mfl_nvm_ctrl

// File: pkg/mfl_pkg.sv
// constants and types for the nonvolatile access and fault-log control block
package mfl_pkg;

	// -------------------------------------------------------------
	// register offsets
	// -------------------------------------------------------------
	localparam logic [7:0] ADDR_LOG_EN = 8'h39;
	localparam logic [7:0] ADDR_CMD = 8'h3A;
	localparam logic [7:0] ADDR_TADDR = 8'h3B;
	localparam logic [7:0] ADDR_DIN_HI = 8'h3C;
	localparam logic [7:0] ADDR_DIN_LO = 8'h3D;

	// -------------------------------------------------------------
	// nonvolatile map
	// -------------------------------------------------------------
	localparam logic [7:0] NVM_FIRST = 8'h80;
	localparam logic [7:0] NVM_LAST = 8'hBF;
	localparam logic [7:0] NVM_CFG_FIRST = 8'h8E;
	localparam logic [7:0] NVM_CFG_LAST = 8'hB9;
	localparam logic [7:0] NVM_LOG_BASE = 8'h82;
	localparam logic [7:0] NVM_LOG_STATUS = 8'h8C;
	localparam logic [7:0] SRAM_ADDR_MASK = 8'h7F;
	localparam int NVM_DEPTH = 64;
	localparam int NVM_AW = 6;
	localparam int NVM_DW = 8;

	// -------------------------------------------------------------
	// reset values and field layout
	// -------------------------------------------------------------
	localparam logic [7:0] LOG_EN_RST = 8'h1F;
	localparam logic [7:0] LOG_EN_MASK = 8'h9F;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic [7:0] CMD_MASK = 8'hF8;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam int LOG_MASTER_BIT = 7;
	localparam int NUM_CHAN = 5;
	localparam int CMD_FULL_BIT = 7;
	localparam int CMD_WORD_BIT = 6;
	localparam int CMD_RELOAD_BIT = 5;
	localparam int CMD_MANUAL_BIT = 4;
	localparam int CMD_READ_BIT = 3;

	// -------------------------------------------------------------
	// timing
	// -------------------------------------------------------------
	localparam int unsigned CLK_KHZ = 200000;
	localparam int unsigned FULL_STORE_MS = 650;
	localparam int unsigned WORD_STORE_MS = 25;
	localparam int unsigned FULL_STORE_CYCLES = FULL_STORE_MS * CLK_KHZ;
	localparam int unsigned WORD_STORE_CYCLES = WORD_STORE_MS * CLK_KHZ;
	localparam logic [31:0] WAIT_ONE = 32'h0000_0001;

	// -------------------------------------------------------------
	// types
	// -------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_COPY = 2'b01,
		ST_WAIT = 2'b11,
		ST_DONE = 2'b10
	} mfl_state_t;

	typedef enum logic [2:0] {
		OP_FULL = 3'h0,
		OP_WORD = 3'h1,
		OP_RELOAD = 3'h2,
		OP_MANUAL = 3'h3,
		OP_LOG = 3'h4
	} mfl_op_t;

endpackage : mfl_pkg

// File: logic/mfl_nvm_mem.sv
// nonvolatile byte array with one write port and two registered read ports
`timescale 1ns/100ps
module mfl_nvm_mem #(
	parameter int DEPTH = 64,
	parameter int AW = 6,
	parameter int DW = 8
) (
	input wire logic clk, // system clock
	input wire logic rstn, // synchronous reset, active low
	input wire logic wr_en, // write strobe
	input wire logic [AW-1:0] wr_addr, // write index
	input wire logic [DW-1:0] wr_data, // write byte
	input wire logic [AW-1:0] a_addr, // host read index
	output logic [DW-1:0] a_rdata, // host read byte, next cycle
	input wire logic [AW-1:0] b_addr, // sequencer read index
	output logic [DW-1:0] b_rdata // sequencer read byte, next cycle
);

	logic [DW-1:0] mem [DEPTH];

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			a_rdata <= '0;
			b_rdata <= '0;
		end
		else
		begin
			a_rdata <= mem[a_addr];
			b_rdata <= mem[b_addr];
		end
	end

endmodule : mfl_nvm_mem

// File: logic/mfl_nvm_ctrl_fix.sv
`timescale 1ns/100ps

// File: verification/mfl_sram_model.sv
// configuration bank model on the far side of the sequencer
`timescale 1ns/100ps
module mfl_sram_model (
	input wire logic clk, // system clock
	input wire logic [7:0] rd_addr, // read address
	output logic [7:0] rd_data, // byte at rd_addr
	input wire logic wr, // write strobe
	input wire logic [7:0] wr_addr, // write address
	input wire logic [7:0] wr_data // write byte
);
	// -------------------------------------------------------------
	// byte array, open to the bench
	// -------------------------------------------------------------
	logic [7:0] mem [128];
	assign rd_data = mem[rd_addr[6:0]];
	always @(posedge clk)
	begin
		if (wr)
			mem[wr_addr[6:0]] <= wr_data;
	end
endmodule : mfl_sram_model

// File: verification/mfl_nvm_ctrl_properties.sv
// port assertions for the nonvolatile access control block
`timescale 1ns/100ps
module mfl_nvm_ctrl_properties #(
	parameter int unsigned FULL_CYCLES = mfl_pkg::FULL_STORE_CYCLES,
	parameter int unsigned WORD_CYCLES = mfl_pkg::WORD_STORE_CYCLES
) (
	input wire logic clk, // system clock
	input wire logic rstn, // reset, active low
	input wire logic [7:0] reg_addr, // register address
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [7:0] reg_wdata, // write data
	input wire logic [7:0] reg_rdata, // read data
	input wire logic reg_rvalid, // read valid
	input wire logic cfg_wr, // bank write strobe
	input wire logic [7:0] cfg_wr_addr, // bank write address
	input wire logic fault_valid, // fault pulse
	input wire logic nvm_busy // sequencer working
);
	// -------------------------------------------------------------
	// shadow of host writes and count of consecutive busy cycles
	// -------------------------------------------------------------
	logic en_q, en_d, rden_q, rden_d;
	logic [31:0] busy_q, busy_d;
	always_comb
	begin
		en_d = en_q;
		rden_d = rden_q;
		busy_d = nvm_busy ? busy_q + 32'h1 : 32'h0;
		if (reg_wr && reg_addr == 8'h39)
			en_d = reg_wdata[7];
		if (reg_wr && reg_addr == 8'h3A)
			rden_d = reg_wdata[3];
	end
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			en_q <= 1'b0;
			rden_q <= 1'b0;
			busy_q <= 32'h0;
		end
		else
		begin
			en_q <= en_d;
			rden_q <= rden_d;
			busy_q <= busy_d;
		end
	end
	// -------------------------------------------------------------
	// properties
	// -------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	a_rvalid_lat: assert property (reg_rd |-> ##2 reg_rvalid)
		else $error("read answer late");
	a_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd, 2))
		else $error("read answer without read");
	a_nvm_read_zero: assert property (reg_rd && reg_addr[7:6] == 2'b10 && !rden_q
		|-> ##2 reg_rdata == 8'h00)
		else $error("array read while disabled");
	a_cmd_reserved: assert property (reg_rd && reg_addr == 8'h3A
		|-> ##2 reg_rdata[2:0] == 3'h0)
		else $error("command reserved bits set");
	a_log_reserved: assert property (reg_rd && reg_addr == 8'h39
		|-> ##2 reg_rdata[6:5] == 2'h0)
		else $error("log enable reserved bits set");
	a_log_gate: assert property (fault_valid && !en_q && !nvm_busy && !reg_wr
		|=> !nvm_busy [*2])
		else $error("fault logged with master off");
	a_start_busy: assert property (reg_wr && reg_addr == 8'h3A
		&& reg_wdata[7:4] != 4'h0 && !nvm_busy |-> ##2 nvm_busy)
		else $error("command did not start");
	a_cfg_wr_pulse: assert property (cfg_wr |-> nvm_busy ##1 !cfg_wr)
		else $error("bank write not a paced pulse");
	a_cfg_range: assert property (cfg_wr |-> cfg_wr_addr >= 8'h0E && cfg_wr_addr <= 8'h39)
		else $error("bank write out of range");
	a_busy_bound: assert property (busy_q <= FULL_CYCLES + 32'h0000_00C8)
		else $error("sequencer stuck busy");
	a_reset_quiet: assert property (disable iff (1'b0) !rstn
		|=> !nvm_busy && !reg_rvalid && !cfg_wr)
		else $error("outputs active in reset");
	c_reload: cover property (cfg_wr);
	c_busy: cover property ($fell(nvm_busy));
	c_fault: cover property (fault_valid && en_q);
endmodule : mfl_nvm_ctrl_properties
bind mfl_nvm_ctrl mfl_nvm_ctrl_properties #(.FULL_CYCLES(FULL_CYCLES),
	.WORD_CYCLES(WORD_CYCLES)) u_chk (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .cfg_wr(cfg_wr), .cfg_wr_addr(cfg_wr_addr),
	.fault_valid(fault_valid), .nvm_busy(nvm_busy));

// File: verification/mfl_nvm_ctrl_tb_top.sv
// self-checking bench for the nonvolatile access control block
`timescale 1ns/100ps
module mfl_nvm_ctrl_tb_top;
	logic clk, rstn, reg_wr, reg_rd, reg_rvalid, cfg_wr, fault_valid, nvm_busy;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, cfg_rd_addr, cfg_rd_data;
	logic [7:0] cfg_wr_addr, cfg_wr_data, fault_status;
	logic [2:0] fault_chan;
	logic [15:0] fault_temp;
	int miscompares = 0;
	int checks = 0;
	// host pause after a log-enable write, scaled down like the store waits
	localparam int LOG_EN_SETTLE = 50;
	logic [7:0] ta [6] = '{8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'h50};
	logic [7:0] tw [6] = '{8'h9F, 8'h0F, 8'hA5, 8'h5A, 8'hC3, 8'h77};
	logic [7:0] te [6] = '{8'h9F, 8'h08, 8'hA5, 8'h5A, 8'hC3, 8'h00};
	mfl_nvm_ctrl #(.FULL_CYCLES(20), .WORD_CYCLES(8)) dut (.clk(clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cfg_rd_addr(cfg_rd_addr),
		.cfg_rd_data(cfg_rd_data), .cfg_wr(cfg_wr), .cfg_wr_addr(cfg_wr_addr),
		.cfg_wr_data(cfg_wr_data), .fault_valid(fault_valid), .fault_chan(fault_chan),
		.fault_temp(fault_temp), .fault_status(fault_status), .nvm_busy(nvm_busy));
	mfl_sram_model sram (.clk(clk), .rd_addr(cfg_rd_addr), .rd_data(cfg_rd_data),
		.wr(cfg_wr), .wr_addr(cfg_wr_addr), .wr_data(cfg_wr_data));
	// -------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------
	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		checks++;
		if (s !== e)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk);
		reg_wr = 1'b0;
		@(negedge clk);
		if (a == 8'h39)
			repeat (LOG_EN_SETTLE) @(negedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd = 1'b1;
		reg_addr = a;
		@(negedge clk);
		reg_rd = 1'b0;
		@(negedge clk);
		chk("rvalid", {7'h0, reg_rvalid}, 8'h01);
		chk("rdata", reg_rdata, e);
	endtask : rd
	task automatic idle();
		repeat (2) @(negedge clk);
		for (int k = 0; k < 400 && nvm_busy === 1'b1; k++)
			@(negedge clk);
		chk("busy", {7'h0, nvm_busy}, 8'h00);
	endtask : idle
	task automatic fault(input logic [15:0] t, input logic [7:0] s);
		fault_valid = 1'b1;
		fault_chan = 3'h2;
		fault_temp = t;
		fault_status = s;
		@(negedge clk);
		fault_valid = 1'b0;
	endtask : fault
	task automatic stop_test();
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : stop_test
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	initial
	begin
		#100000;
		miscompares++;
		stop_test();
	end
	// -------------------------------------------------------------
	// sequence
	// -------------------------------------------------------------
	initial
	begin
		{rstn, reg_wr, reg_rd, fault_valid, reg_addr, reg_wdata} = '0;
		{fault_chan, fault_temp, fault_status} = '0;
		for (int i = 0; i < 128; i++)
			sram.mem[i] = 8'(i) ^ 8'h5A;
		@(posedge clk);
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			wr(ta[i], tw[i]);
			rd(ta[i], te[i]);
		end
		rstn = 1'b0;
		repeat (12) @(negedge clk);
		rstn = 1'b1;
		for (int i = 0; i < 5; i++)
			rd(8'h39 + 8'(i), i == 0 ? 8'h1F : 8'h00);
		wr(8'h3A, 8'h88);
		idle();
		rd(8'h3A, 8'h08);
		rd(8'h8E, 8'h0E ^ 8'h5A);
		rd(8'hB9, 8'h39 ^ 8'h5A);
		sram.mem[8'h1D] = 8'h11;
		sram.mem[8'h1E] = 8'h22;
		sram.mem[8'h1F] = 8'h33;
		sram.mem[8'h20] = 8'h44;
		wr(8'h3B, 8'h9D);
		wr(8'h3A, 8'h48);
		idle();
		rd(8'h3A, 8'h08);
		rd(8'h9D, 8'h11);
		rd(8'h9E, 8'h22);
		wr(8'h3B, 8'hA0);
		wr(8'h3A, 8'h48);
		idle();
		rd(8'h9F, 8'h33);
		rd(8'hA0, 8'h44);
		sram.mem[8'h20] = 8'h00;
		wr(8'h3A, 8'h28);
		idle();
		chk("reload", sram.mem[8'h20], 8'h44);
		wr(8'h3C, 8'h12);
		wr(8'h3D, 8'h34);
		wr(8'h3B, 8'h81);
		wr(8'h3A, 8'h18);
		idle();
		rd(8'h80, 8'h12);
		rd(8'h81, 8'h34);
		wr(8'h39, 8'h9F);
		fault(16'hBEEF, 8'h44);
		idle();
		rd(8'h86, 8'hBE);
		rd(8'h87, 8'hEF);
		rd(8'h8C, 8'h44);
		wr(8'h39, 8'h1F);
		fault(16'h1111, 8'h55);
		repeat (3) @(negedge clk);
		chk("gated", {7'h0, nvm_busy}, 8'h00);
		rd(8'h86, 8'hBE);
		wr(8'h3A, 8'h00);
		rd(8'h80, 8'h00);
		stop_test();
	end
endmodule : mfl_nvm_ctrl_tb_top
